/* sas_sdram_access_sequencer.sv */
// Synchronous DRAM access sequencer: fills, single reads, writes, bank-active.
// Assumes DRAM runs on ref_clk; refresh and arbitration pulses from the
// surrounding controller on the same clock.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`include "sas_map.svh"
`default_nettype none
module sas_sdram_access_sequencer #(
  parameter int ADDR_W = 27,
  parameter int ROW_W = 12,
  parameter int ROW_LO = 10,
  parameter int BANK_BIT = 22
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_area3,
  input wire logic req_full_burst,
  input wire logic [3:0] req_byte_en,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [31:0] req_wdata,
  output logic req_ready,
  input wire logic refresh_done,
  input wire logic bus_released,
  output sas_pkg::sas_cmd_t dram_cmd,
  output logic dram_bank,
  output logic [ROW_W-1:0] dram_addr,
  output logic [3:0] byte_mask_lines,
  output logic [31:0] dq_out,
  output logic dq_oe_n,
  input wire logic [31:0] dq_in,
  output logic bus_cycle_strobe_n,
  output logic [2:0] burst_offset,
  output logic [31:0] rd_data,
  output logic rd_valid,
  output logic access_done
);
  // Row and bank bits must sit inside the address; both rows fit one word
  if (ROW_LO + ROW_W > ADDR_W || BANK_BIT >= ADDR_W || ROW_LO < 4
      || 2 * ROW_W > 32) begin : g_bad_split
    $error("sas: address split does not fit");
  end

  sas_pkg::sas_state_t state, next_state;
  sas_pkg::sas_cmd_t next_cmd;
  logic [7:0] memory_control_register;
  logic [2:0] cnt, next_cnt, dcnt;
  logic [15:0] hit_count;
  logic [1:0] bank_valid;
  logic [ROW_W-1:0] bank_row [2];
  logic [ADDR_W-1:0] a_addr;
  logic [31:0] a_wdata;
  logic [3:0] a_be;
  logic a_write, a_full, a_active, a_area3;

  // Configuration decode
  wire keep_open = memory_control_register[`SAS_MCR_KEEP];
  wire trp_long = memory_control_register[`SAS_MCR_TRP];
  wire [2:0] trp_cyc = trp_long ? 3'h2 : 3'h1;
  wire [2:0] twr_cyc = {1'b0, memory_control_register[`SAS_MCR_WRITE_RECOVERY_SETTING_LO+1:`SAS_MCR_WRITE_RECOVERY_SETTING_LO]} + 3'h1;
  wire [1:0] cl_code = memory_control_register[`SAS_MCR_CL_LO+1:`SAS_MCR_CL_LO];
  wire cl_one = (cl_code == 2'h0);
  wire wide = memory_control_register[`SAS_MCR_WIDE];
  wire [2:0] tap_rd = cl_one ? trp_cyc : trp_cyc - 3'h1;

  // Request decode and hit check
  wire accept = req_valid && req_ready;
  wire req_bank = req_addr[BANK_BIT];
  wire [ROW_W-1:0] req_row = req_addr[ROW_LO +: ROW_W];
  wire use_active = keep_open && req_area3;
  wire row_hit = use_active && bank_valid[req_bank]
                 && (bank_row[req_bank] == req_row);
  wire row_miss = use_active && bank_valid[req_bank] && !row_hit;
  wire a_bank = a_addr[BANK_BIT];
  wire invalidate = refresh_done || bus_released;

  // Data cycle decode
  wire [2:0] last_beat = wide ? `SAS_WIDE_LAST : `SAS_NARROW_LAST;
  wire is_long = (a_be == 4'hF);
  wire [2:0] ncap = (!wide && is_long) ? 3'h2 : 3'h1;
  // Only the wanted beats are taken; the burst always runs to its end
  wire capture = (state == sas_pkg::SAS_DATA)
                 && (a_full || dcnt < ncap);
  wire beat_end = (state == sas_pkg::SAS_DATA) && (dcnt == last_beat);
  wire [2:0] step = wide ? 3'h2 : 3'h1;
  wire autoclose = !a_active;

  always_comb begin
    next_state = state;
    next_cmd = sas_pkg::SAS_NOP;
    next_cnt = (cnt != 3'h0) ? cnt - 3'h1 : 3'h0;
    unique case (state)
      sas_pkg::SAS_IDLE: begin
        if (accept) begin
          if (row_hit) begin
            // CL1 needs a spare cycle for the two-cycle mask latency
            next_state = (!req_write && cl_one) ? sas_pkg::SAS_GAP
                                                : sas_pkg::SAS_COL;
          end else if (row_miss) begin
            next_state = sas_pkg::SAS_PRE;
          end else begin
            next_state = sas_pkg::SAS_ACT;
          end
        end
      end
      sas_pkg::SAS_PRE: begin
        next_cmd = sas_pkg::SAS_PRECHARGE;
        next_state = trp_long ? sas_pkg::SAS_PWAIT : sas_pkg::SAS_ACT;
      end
      sas_pkg::SAS_PWAIT: begin
        next_state = sas_pkg::SAS_ACT;
      end
      sas_pkg::SAS_ACT: begin
        next_cmd = sas_pkg::SAS_ROW_OPEN;
        next_state = sas_pkg::SAS_COL;
      end
      sas_pkg::SAS_GAP: begin
        next_state = sas_pkg::SAS_COL;
      end
      sas_pkg::SAS_COL: begin
        if (a_write) begin
          next_cmd = autoclose ? sas_pkg::SAS_STORE_AC
                               : sas_pkg::SAS_STORE;
          next_state = autoclose ? sas_pkg::SAS_RECOV : sas_pkg::SAS_IDLE;
          next_cnt = twr_cyc - 3'h1;
        end else begin
          next_cmd = autoclose ? sas_pkg::SAS_FETCH_AC
                               : sas_pkg::SAS_FETCH;
          // Command cycle on the pins is not a data cycle; wait full latency
          next_state = sas_pkg::SAS_CASW;
          next_cnt = {1'b0, cl_code};
        end
      end
      sas_pkg::SAS_CASW: begin
        if (cnt == 3'h0) begin
          next_state = sas_pkg::SAS_DATA;
        end
      end
      sas_pkg::SAS_DATA: begin
        if (beat_end) begin
          next_state = (autoclose && tap_rd != 3'h0) ? sas_pkg::SAS_APW
                                                     : sas_pkg::SAS_IDLE;
          next_cnt = tap_rd - 3'h1;
        end
      end
      sas_pkg::SAS_RECOV: begin
        if (cnt == 3'h0) begin
          next_state = sas_pkg::SAS_APW;
          next_cnt = trp_cyc - 3'h1;
        end
      end
      sas_pkg::SAS_APW: begin
        if (cnt == 3'h0) begin
          next_state = sas_pkg::SAS_IDLE;
        end
      end
    endcase
  end

  wire next_drive = (next_cmd == sas_pkg::SAS_STORE)
                    || (next_cmd == sas_pkg::SAS_STORE_AC);
  wire next_done = (next_state == sas_pkg::SAS_IDLE)
                   && (state != sas_pkg::SAS_IDLE);
  wire [ROW_W-1:0] col_addr = {{(ROW_W-ROW_LO+1){1'b0}}, a_addr[ROW_LO-1:1]};
  wire [ROW_W-1:0] next_dram_addr = (next_cmd == sas_pkg::SAS_ROW_OPEN)
                                    ? a_addr[ROW_LO +: ROW_W] : col_addr;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state <= sas_pkg::SAS_IDLE;
      cnt <= 3'h0;
      req_ready <= 1'b0;
      access_done <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      req_ready <= (next_state == sas_pkg::SAS_IDLE);
      access_done <= next_done;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      a_addr <= '0;
      a_wdata <= 32'h0000_0000;
      a_be <= 4'h0;
      a_write <= 1'b0;
      a_full <= 1'b0;
      a_active <= 1'b0;
      a_area3 <= 1'b0;
    end else if (accept) begin
      a_addr <= req_addr;
      a_wdata <= req_wdata;
      a_be <= req_byte_en;
      a_write <= req_write;
      a_full <= req_full_burst && !req_write;
      a_active <= use_active;
      a_area3 <= req_area3;
    end
  end

  // Pin stage: every pin changes on the rising edge
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      dram_cmd <= sas_pkg::SAS_NOP;
      dram_bank <= 1'b0;
      dram_addr <= '0;
      byte_mask_lines <= 4'h0;
      dq_out <= 32'h0000_0000;
      dq_oe_n <= 1'b1;
    end else begin
      dram_cmd <= next_cmd;
      dram_bank <= a_bank;
      dram_addr <= next_dram_addr;
      byte_mask_lines <= next_drive ? ~a_be : 4'h0;
      dq_out <= next_drive ? a_wdata : 32'h0000_0000;
      dq_oe_n <= !next_drive;
    end
  end

  // Read capture; strobe marks exactly the beats that are kept
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      dcnt <= 3'h0;
      rd_data <= 32'h0000_0000;
      rd_valid <= 1'b0;
      bus_cycle_strobe_n <= 1'b1;
      burst_offset <= 3'h0;
    end else begin
      dcnt <= (state == sas_pkg::SAS_DATA) ? dcnt + 3'h1 : 3'h0;
      rd_valid <= capture;
      bus_cycle_strobe_n <= !capture;
      if (capture) begin
        rd_data <= dq_in;
        burst_offset <= burst_offset + step;
      end else if (state != sas_pkg::SAS_DATA) begin
        burst_offset <= a_addr[3:1];
      end
    end
  end

  // Open-row table; clearing events win over a fresh row open
  for (genvar b = 0; b < 2; b++) begin : g_bank
    wire opening = (state == sas_pkg::SAS_ACT) && a_area3
                   && (a_bank == 1'(b));
    always_ff @(posedge ref_clk) begin
      if (!reset_n || invalidate) begin
        bank_valid[b] <= 1'b0;
        bank_row[b] <= '0;
      end else if (opening) begin
        bank_valid[b] <= a_active;
        bank_row[b] <= a_addr[ROW_LO +: ROW_W];
      end
    end
  end

  // Register port
  wire sel_mcr = reg_addr == `SAS_MCR_OFF;
  wire sel_stat = reg_addr == `SAS_STAT_OFF;
  wire sel_hits = reg_addr == `SAS_HITS_OFF;
  wire sel_rows = reg_addr == `SAS_ROWS_OFF;
  wire busy = state != sas_pkg::SAS_IDLE;
  wire [31:0] rows_word = {{(32-2*ROW_W){1'b0}}, bank_row[1], bank_row[0]};
  wire [31:0] next_rdata =
    sel_mcr ? {24'h00_0000, memory_control_register} :
    sel_stat ? {29'h0000_0000, busy, bank_valid} :
    sel_hits ? {16'h0000, hit_count} :
    sel_rows ? rows_word : 32'h0000_0000;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      memory_control_register <= `SAS_MCR_RESET;
      hit_count <= 16'h0000;
      reg_rdata <= 32'h0000_0000;
    end else begin
      if (reg_wr && sel_mcr) begin
        memory_control_register <= {1'b0, reg_wdata[6:0]};
      end
      if (reg_wr && sel_hits) begin
        hit_count <= 16'h0000;
      end else if (accept && row_hit) begin
        hit_count <= hit_count + 16'h0001;
      end
      reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
    end
  end

  default clocking sas_cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  wire hit_accept = accept && row_hit && !req_write;

  a_open_then_col: assert property (
    dram_cmd == sas_pkg::SAS_ROW_OPEN |=> dram_cmd inside
      {sas_pkg::SAS_FETCH, sas_pkg::SAS_FETCH_AC,
       sas_pkg::SAS_STORE, sas_pkg::SAS_STORE_AC})
    else $error("row open not followed by column command");
  a_store_data: assert property (
    (dram_cmd == sas_pkg::SAS_STORE_AC || dram_cmd == sas_pkg::SAS_STORE)
      == !dq_oe_n)
    else $error("write data not aligned with store command");
  a_empty_quiet: assert property (
    $past(state) == sas_pkg::SAS_DATA |-> dram_cmd == sas_pkg::SAS_NOP && dq_oe_n)
    else $error("command or data during read beats");
  a_close_short: assert property (
    dram_cmd == sas_pkg::SAS_PRECHARGE && !trp_long
      |=> dram_cmd == sas_pkg::SAS_ROW_OPEN)
    else $error("short precharge spacing wrong");
  a_close_long: assert property (
    dram_cmd == sas_pkg::SAS_PRECHARGE && trp_long
      |=> dram_cmd == sas_pkg::SAS_NOP ##1 dram_cmd == sas_pkg::SAS_ROW_OPEN)
    else $error("long precharge spacing wrong");
  a_strobe_kept: assert property (
    !bus_cycle_strobe_n == rd_valid)
    else $error("strobe differs from captured beat");
  a_hit_no_open: assert property (
    accept && row_hit |=> (dram_cmd != sas_pkg::SAS_ROW_OPEN)[*3])
    else $error("row open issued on a hit");
  a_gap_cl1: assert property (
    hit_accept && cl_one |-> ##3 dram_cmd == sas_pkg::SAS_FETCH)
    else $error("latency one hit gap missing");
  a_gap_none: assert property (
    hit_accept && !cl_one |-> ##2 dram_cmd == sas_pkg::SAS_FETCH)
    else $error("needless gap on hit");
  a_banks_clear: assert property (
    invalidate |=> bank_valid == 2'b00)
    else $error("banks not cleared");
  a_other_area: assert property (
    state == sas_pkg::SAS_ACT && !a_area3 && !invalidate |=> $stable(bank_valid))
    else $error("other area changed open rows");

  c_fill: cover property (accept && req_full_burst && !req_write);
  c_row_miss: cover property (dram_cmd == sas_pkg::SAS_PRECHARGE);
  c_write_ac: cover property (dram_cmd == sas_pkg::SAS_STORE_AC);
  c_hit_cl1: cover property (hit_accept && cl_one);
endmodule : sas_sdram_access_sequencer
`default_nettype wire

/* sas_map.svh */
// Register offsets, field positions, reset values and timing counts.
// Assumes a 40 MHz ref_clk and a plain strobe-style register port.
// Functional notes
// - Cache-fill misses read a whole 16-byte burst, every word valid.
// - Uncached reads keep at most 32 bits; rest of burst discarded.
// - Narrow DMA reads still run the full burst, unused data dropped.
// - 32-bit single read: capture and strobe first data cycle only.
// - 16-bit width: eight data cycles; longword two captures, else one.
// - Basic write: row open, then store with autoclose next cycle.
// - Write data driven in the same cycle as the store command.
// - After autoclose store wait write recovery plus precharge cycles.
// - Keep-row-open bit set: plain commands for area three, row stays open.
// - Bank-active row hit issues column command without row open.
// - One open row tracked per bank, two banks independently.
// - Row miss: precharge, then row open, then column command.
// - Precharge to row open spacing follows close-to-open setting.
// - Read hit with CAS latency 1 inserts one idle cycle first.
// - Tracking only for area three; other areas leave it untouched.
// - Refresh end or bus release marks both banks inactive.
// - Read autoclose wait: setting for latency 1, setting-1 otherwise.
// - Cache-fill burst asserts the strobe in every data cycle.
// - Low burst address bits advance with every captured word.
`ifndef SAS_MAP_SVH
`define SAS_MAP_SVH
`define SAS_MCR_OFF 4'h0
`define SAS_STAT_OFF 4'h4
`define SAS_HITS_OFF 4'h8
`define SAS_ROWS_OFF 4'hC
`define SAS_MCR_KEEP 0
`define SAS_MCR_TRP 1
`define SAS_MCR_WRITE_RECOVERY_SETTING_LO 2
`define SAS_MCR_CL_LO 4
`define SAS_MCR_WIDE 6
`define SAS_MCR_RESET 8'h00
`define SAS_WIDE_LAST 3'h3
`define SAS_NARROW_LAST 3'h7
`endif

/* sas_pkg.sv */
// Types shared by the access sequencer.
// Assumes the command codes are decoded to pins by the pad logic.
`default_nettype none
package sas_pkg;
  typedef enum logic [2:0] {
    SAS_NOP, SAS_ROW_OPEN, SAS_FETCH, SAS_FETCH_AC,
    SAS_STORE, SAS_STORE_AC, SAS_PRECHARGE
  } sas_cmd_t;
  typedef enum {
    SAS_IDLE, SAS_PRE, SAS_PWAIT, SAS_ACT, SAS_GAP, SAS_COL,
    SAS_CASW, SAS_DATA, SAS_RECOV, SAS_APW
  } sas_state_t;
endpackage : sas_pkg
`default_nettype wire

/* sas_dram_model.sv */
// Far-side DRAM model: tracks open rows, returns data after fetches.
// Assumes commands are registered on ref_clk; data stays 12 cycles.
`default_nettype none
module sas_dram_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire sas_pkg::sas_cmd_t dram_cmd,
  input wire logic dram_bank,
  input wire logic [11:0] dram_addr,
  input wire logic all_closed,
  output logic [31:0] dq_in,
  output logic [7:0] bad_cmds
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] row [2];
  logic [1:0] open;
  logic [3:0] left;
  logic [31:0] word;
  logic [31:0] noise;
  wire is_col = dram_cmd inside {sas_pkg::SAS_FETCH, sas_pkg::SAS_FETCH_AC,
    sas_pkg::SAS_STORE, sas_pkg::SAS_STORE_AC};
  wire is_ac = dram_cmd inside {sas_pkg::SAS_FETCH_AC, sas_pkg::SAS_STORE_AC};
  wire is_rd = dram_cmd inside {sas_pkg::SAS_FETCH, sas_pkg::SAS_FETCH_AC};
  // Undriven bus flips every cycle so a stale capture cannot match
  assign dq_in = (left != 4'h0) ? word : noise;
  always_ff @(posedge ref_clk) begin
    noise <= ~noise;
    if (!reset_n) begin
      open <= 2'b00;
      left <= 4'h0;
      bad_cmds <= 8'h00;
      noise <= 32'h0F0F_0F0F;
    end else begin
      if (left != 4'h0) left <= left - 4'h1;
      if (all_closed) open <= 2'b00;
      if (dram_cmd == sas_pkg::SAS_ROW_OPEN) begin
        open[dram_bank] <= 1'b1;
        row[dram_bank] <= dram_addr;
      end
      if (dram_cmd == sas_pkg::SAS_PRECHARGE) open[dram_bank] <= 1'b0;
      if (is_col) begin
        if (!open[dram_bank]) bad_cmds <= bad_cmds + 8'h01;
        if (is_ac) open[dram_bank] <= 1'b0;
      end
      if (is_rd) begin
        left <= 4'hC;
        word <= {16'hDA7A, 3'h0, dram_bank, row[dram_bank]};
      end
    end
  end
endmodule : sas_dram_model
`default_nettype wire

/* testbench.sv */
// Bench for the access sequencer: register port tasks and access tasks.
// Assumes the DRAM model on the far side and refresh pulses from here.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, reset_n, reg_wr, reg_rd, req_valid, req_write, req_area3;
  logic req_full_burst, req_ready, refresh_done, bus_released, dram_bank;
  logic dq_oe_n, bus_cycle_strobe_n, rd_valid, access_done;
  logic [3:0] reg_addr, req_byte_en, byte_mask_lines;
  logic [31:0] reg_wdata, reg_rdata, req_wdata, dq_out, dq_in, rd_data, v;
  logic [26:0] req_addr;
  logic [11:0] dram_addr;
  logic [2:0] burst_offset, prev_off, step;
  logic [7:0] bad_cmds;
  sas_pkg::sas_cmd_t dram_cmd, col_cmd;
  int failures, total_checks, beats, stores, i_open, i_pre, i_col, done_k;
  int g0, i;
  logic [7:0] mcr_t [5] = '{8'h40, 8'h40, 8'h00, 8'h00, 8'h00};
  logic [3:0] be_t [5] = '{4'hF, 4'hF, 4'hF, 4'hF, 4'h1};
  int beat_t [5] = '{4, 1, 8, 2, 1};
  sas_sdram_access_sequencer DUT (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
    .req_write(req_write), .req_area3(req_area3),
    .req_full_burst(req_full_burst), .req_byte_en(req_byte_en),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .refresh_done(refresh_done), .bus_released(bus_released),
    .dram_cmd(dram_cmd), .dram_bank(dram_bank), .dram_addr(dram_addr),
    .byte_mask_lines(byte_mask_lines), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .dq_in(dq_in), .bus_cycle_strobe_n(bus_cycle_strobe_n),
    .burst_offset(burst_offset), .rd_data(rd_data), .rd_valid(rd_valid),
    .access_done(access_done));
  sas_dram_model far_side (.ref_clk(ref_clk), .reset_n(reset_n),
    .dram_cmd(dram_cmd), .dram_bank(dram_bank), .dram_addr(dram_addr),
    .all_closed(refresh_done | bus_released), .dq_in(dq_in),
    .bad_cmds(bad_cmds));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  task automatic check(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : check
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= {24'h00_0000, d};
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : reg_read
  task automatic pulse(input logic which);
    @(posedge ref_clk);
    if (which) bus_released <= 1'b1;
    else refresh_done <= 1'b1;
    @(posedge ref_clk);
    bus_released <= 1'b0;
    refresh_done <= 1'b0;
  endtask : pulse
  task automatic access(input logic wr, a3, full, input logic [3:0] be,
      input logic bk, input logic [11:0] rw);
    int k;
    logic [31:0] wd;
    wd = {16'h5E7D, 4'h0, rw};
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_area3 <= a3;
    req_full_burst <= full;
    req_byte_en <= be;
    req_addr <= {4'h0, bk, rw, 10'h000};
    req_wdata <= wd;
    k = 0;
    @(negedge ref_clk);
    while (req_ready !== 1'b1 && k < 40) begin
      @(negedge ref_clk);
      k++;
    end
    if (k == 40) begin
      failures++;
      final_report();
    end
    @(posedge ref_clk);
    req_valid <= 1'b0;
    {beats, stores, i_open, i_pre, i_col, done_k} = {6{-32'sd1}};
    beats = 0;
    stores = 0;
    for (k = 1; k <= 60 && done_k < 0; k++) begin
      @(negedge ref_clk);
      if (dram_cmd == sas_pkg::SAS_ROW_OPEN && i_open < 0) i_open = k;
      if (dram_cmd == sas_pkg::SAS_PRECHARGE && i_pre < 0) i_pre = k;
      if (dram_cmd inside {sas_pkg::SAS_FETCH, sas_pkg::SAS_FETCH_AC,
          sas_pkg::SAS_STORE, sas_pkg::SAS_STORE_AC}) begin
        i_col = k;
        col_cmd = dram_cmd;
      end
      check(bus_cycle_strobe_n === ~rd_valid, "strobe vs beat");
      check(wr || dq_oe_n === 1'b1, "drove data on read");
      if (dq_oe_n === 1'b0) begin
        stores++;
        check(dq_out === wd && dram_cmd == col_cmd, "store data");
        check(byte_mask_lines === ~be, "byte mask");
      end
      if (rd_valid === 1'b1) begin
        check(rd_data === {16'hDA7A, 3'h0, bk, rw}, "read word");
        if (beats > 0) check(burst_offset === prev_off + step, "offset");
        prev_off = burst_offset;
        beats++;
      end
      if (access_done === 1'b1) done_k = k;
    end
    if (done_k < 0) begin
      failures++;
      final_report();
    end
  endtask : access
  initial begin
    {reset_n, reg_wr, reg_rd, req_valid, req_write, req_area3} = 6'h00;
    {req_full_burst, refresh_done, bus_released} = 3'h0;
    {reg_addr, req_byte_en, reg_wdata, req_wdata, req_addr} = '0;
    step = 3'h2;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    reg_read(4'h0, v);
    check(v === 32'h0000_0000, "control reset");
    reg_read(4'h2, v);
    check(v === 32'h0000_0000, "unmapped read");
    // Fill, single and narrow read shapes, basic mode, CAS latency 1
    for (i = 0; i < 5; i++) begin
      reg_write(4'h0, mcr_t[i]);
      step = mcr_t[i][6] ? 3'h2 : 3'h1;
      access(1'b0, 1'b0, i == 0 || i == 2, be_t[i], 1'b0, 12'h011);
      check(beats == beat_t[i], "beat count");
      check(i_open == 2 && i_col == 3, "basic read");
      check(col_cmd == sas_pkg::SAS_FETCH_AC, "autoclose read");
    end
    reg_write(4'h0, 8'h40);
    access(1'b1, 1'b0, 1'b0, 4'h3, 1'b0, 12'h022);
    check(col_cmd == sas_pkg::SAS_STORE_AC && i_col == i_open + 1, "wr");
    check(stores == 1, "one store cycle");
    g0 = done_k - i_col;
    reg_write(4'h0, 8'h4E);
    access(1'b1, 1'b0, 1'b0, 4'hF, 1'b0, 12'h022);
    check(done_k - i_col == g0 + 4, "write recovery");
    // Bank-active mode
    reg_write(4'h0, 8'h41);
    access(1'b0, 1'b1, 1'b0, 4'hF, 1'b0, 12'h005);
    check(i_open == 2 && col_cmd == sas_pkg::SAS_FETCH, "plain read");
    access(1'b0, 1'b1, 1'b0, 4'hF, 1'b0, 12'h005);
    check(i_open < 0 && i_col == 3, "hit CL1");
    access(1'b0, 1'b1, 1'b0, 4'hF, 1'b1, 12'h007);
    check(i_open == 2 && i_pre < 0, "other bank");
    reg_read(4'h4, v);
    check(v[1:0] === 2'b11, "both valid");
    // Other areas sit on another device; bank 1 keeps it off the open row
    access(1'b0, 1'b0, 1'b0, 4'hF, 1'b1, 12'h005);
    reg_read(4'h4, v);
    check(v[1:0] === 2'b11, "other area kept valid");
    reg_read(4'hC, v);
    check(v === 32'h0000_7005, "open rows");
    access(1'b0, 1'b1, 1'b0, 4'hF, 1'b0, 12'h005);
    check(i_open < 0, "other area kept row");
    access(1'b0, 1'b1, 1'b0, 4'hF, 1'b0, 12'h006);
    check(i_pre == 2 && i_open == 3, "row miss");
    reg_write(4'h0, 8'h43);
    access(1'b0, 1'b1, 1'b0, 4'hF, 1'b0, 12'h005);
    check(i_pre == 2 && i_open == 4, "miss trp");
    reg_write(4'h0, 8'h51);
    access(1'b0, 1'b1, 1'b0, 4'hF, 1'b0, 12'h005);
    check(i_open < 0 && i_col == 2, "hit CL2");
    access(1'b1, 1'b1, 1'b0, 4'hF, 1'b0, 12'h005);
    check(i_open < 0 && i_col == 2, "write hit");
    check(col_cmd == sas_pkg::SAS_STORE, "plain store");
    reg_read(4'h8, v);
    check(v === 32'h0000_0004, "row hit count");
    // Refresh end and bus release both close every row
    for (i = 0; i < 2; i++) begin
      pulse(i[0]);
      reg_read(4'h4, v);
      check(v[1:0] === 2'b00, "banks cleared");
      access(1'b0, 1'b1, 1'b0, 4'hF, 1'b0, 12'h005);
      check(i_open == 2 && i_pre < 0, "reopen");
    end
    check(bad_cmds === 8'h00, "column to closed bank");
    final_report();
  end
endmodule : testbench
`default_nettype wire
